// File: core/led_auto_stepper.sv
// auto mode duty stepper with AHB-Lite register slave
// Operation
// - colour B offset in upper first nibble
// - colour A offset in lower first nibble
// - intensity offset in upper second nibble
// - colour C offset in lower second nibble
// - every N+1 frames step the duty store
// - new interval takes effect at boundary, or at once while auto mode is off
// - stepping registers act only in auto mode
// - page A enable bit per module, per COM
// - disabled module: no step, no write back
// - enable bits seven to five read zero
// - stepper is part of LED PWM unit
`timescale 1ns/100ps
module led_auto_stepper
  import led_step_pkg::*;
(
  input  wire logic                  CLK,
  input  wire logic                  RST,
  input  wire logic                  HSEL,
  input  wire logic [31:0]           HADDR,
  input  wire logic [1:0]            HTRANS,
  input  wire logic                  HWRITE,
  input  wire logic [2:0]            HSIZE,
  input  wire logic [31:0]           HWDATA,
  input  wire logic                  HREADY,
  output logic      [31:0]           HRDATA,
  output logic                       HREADYOUT,
  output logic                       HRESP,
  input  wire logic                  FRAME_TICK,
  output logic      [RAM_ADDR_W-1:0] RAM_ADDR,
  output logic                       RAM_RD_EN,
  input  wire logic [DUTY_W-1:0]     RAM_RD_DATA,
  output logic                       RAM_WR_EN,
  output logic      [DUTY_W-1:0]     RAM_WR_DATA
);

  logic [7:0]        color_ab_step_offset;
  logic [7:0]        intensity_colorc_step_offset;
  logic [7:0]        frame_step_interval;
  logic [4:0]        page_a_module_output_enable_low [NUM_COMS];
  logic [1:0]        control;
  logic              auto_mode;
  logic              step_down;

  logic              dph_valid;
  logic              dph_write;
  logic [7:0]        dph_addr;
  logic              aph_take;
  logic [31:0]       next_rdata;
  logic              dph_wr;
  logic              en_hit_wr;
  logic              en_hit_rd;

  logic [7:0]        frame_count;
  logic [7:0]        active_interval;
  logic              step_due;
  logic              step_pending;

  step_state_t       state;
  logic [2:0]        com_idx;
  logic [2:0]        mod_idx;
  logic [1:0]        chan_idx;
  logic              last_module;
  logic              last_item;
  logic              module_enabled;
  logic [OFS_W-1:0]  chan_offset;
  logic [DUTY_W-1:0] stepped_duty;

  assign auto_mode = control[CTRL_AUTO_BIT];
  assign step_down = control[CTRL_DOWN_BIT];

  // ---------------- AHB-Lite slave ----------------
  assign HREADYOUT = 1'b1;
  assign HRESP     = 1'b0;
  assign aph_take  = HSEL && HREADY && HTRANS[1];

  always_ff @(posedge CLK) begin
    if (RST) begin
      dph_valid <= 1'b0;
    end else begin
      dph_valid <= aph_take;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      dph_write <= 1'b0;
    end else begin
      dph_write <= aph_take && HWRITE;
    end
  end

  // address kept for the write that lands one cycle later
  always_ff @(posedge CLK) begin
    if (RST) begin
      dph_addr <= 8'h00;
    end else if (aph_take) begin
      dph_addr <= HADDR[7:0];
    end
  end

  // register writes land in the data phase
  assign dph_wr    = dph_valid && dph_write;
  assign en_hit_wr = (dph_addr >= ADDR_PAGE_A_EN_BASE) && (dph_addr <= ADDR_PAGE_A_EN_LAST) && (dph_addr[1:0] == 2'h0);

  always_ff @(posedge CLK) begin
    if (RST) begin
      color_ab_step_offset <= RST_OFFSET;
    end else if (dph_wr && dph_addr == ADDR_COLOR_AB_OFS) begin
      color_ab_step_offset <= HWDATA[7:0];
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      intensity_colorc_step_offset <= RST_OFFSET;
    end else if (dph_wr && dph_addr == ADDR_INT_COLORC_OFS) begin
      intensity_colorc_step_offset <= HWDATA[7:0];
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      frame_step_interval <= RST_INTERVAL;
    end else if (dph_wr && dph_addr == ADDR_FRAME_INTERVAL) begin
      frame_step_interval <= HWDATA[7:0];
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      control <= RST_CONTROL;
    end else if (dph_wr && dph_addr == ADDR_CONTROL) begin
      control <= HWDATA[1:0];
    end
  end

  // one word per COM; bits seven to five are not stored
  always_ff @(posedge CLK) begin
    if (RST) begin
      for (int i = 0; i < NUM_COMS; i++) begin
        page_a_module_output_enable_low[i] <= RST_ENABLE;
      end
    end else if (dph_wr && en_hit_wr) begin
      page_a_module_output_enable_low[dph_addr[4:2]] <= HWDATA[4:0];
    end
  end

  assign en_hit_rd = (HADDR[7:0] >= ADDR_PAGE_A_EN_BASE) && (HADDR[7:0] <= ADDR_PAGE_A_EN_LAST) && (HADDR[1:0] == 2'h0);

  // read data prepared in the address phase so it stands in the data phase
  always_comb begin
    next_rdata = 32'h0000_0000;
    case (HADDR[7:0])
      ADDR_COLOR_AB_OFS:   next_rdata[7:0] = color_ab_step_offset;
      ADDR_INT_COLORC_OFS: next_rdata[7:0] = intensity_colorc_step_offset;
      ADDR_FRAME_INTERVAL: next_rdata[7:0] = frame_step_interval;
      ADDR_CONTROL:        next_rdata[1:0] = control;
      ADDR_STATUS: begin
        next_rdata[STAT_BUSY_BIT]             = (state != S_IDLE);
        next_rdata[STAT_PEND_BIT]             = step_pending;
        next_rdata[STAT_CNT_LSB +: 8]         = frame_count;
      end
      default: begin
        if (en_hit_rd) begin
          next_rdata[4:0] = page_a_module_output_enable_low[HADDR[4:2]];
        end
      end
    endcase
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      HRDATA <= 32'h0000_0000;
    end else if (aph_take && !HWRITE) begin
      HRDATA <= next_rdata;
    end
  end

  // ---------------- frame interval counter ----------------
  // interval is sampled when a period closes and every cycle while auto mode is off
  always_ff @(posedge CLK) begin
    if (RST) begin
      frame_count <= 8'h00;
    end else if (!auto_mode) begin
      frame_count <= 8'h00;
    end else if (FRAME_TICK) begin
      if (frame_count == active_interval) begin
        frame_count <= 8'h00;
      end else begin
        frame_count <= frame_count + 8'h01;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      active_interval <= RST_INTERVAL;
    end else if (!auto_mode) begin
      active_interval <= frame_step_interval;
    end else if (step_due) begin
      active_interval <= frame_step_interval;
    end
  end

  assign step_due = auto_mode && FRAME_TICK && (frame_count == active_interval);

  // a due step during a running pass waits; set wins over clear
  always_ff @(posedge CLK) begin
    if (RST) begin
      step_pending <= 1'b0;
    end else if (step_due) begin
      step_pending <= 1'b1;
    end else if (state == S_IDLE) begin
      step_pending <= 1'b0;
    end
  end

  // ---------------- stepping pass over the duty store ----------------
  // a skipped module sits at channel 0, so the pass end looks at the module only
  assign last_module    = (com_idx == 3'(NUM_COMS - 1)) && (mod_idx == 3'(NUM_MODULES - 1));
  assign last_item      = last_module && (chan_idx == 2'h3);
  assign module_enabled = page_a_module_output_enable_low[com_idx][mod_idx];

  always_comb begin
    case (chan_idx)
      CH_INTENSITY: chan_offset = intensity_colorc_step_offset[INTENSITY_OFS_LSB +: OFS_W];
      CH_COLOR_A:   chan_offset = color_ab_step_offset[COLOR_A_OFS_LSB +: OFS_W];
      CH_COLOR_B:   chan_offset = color_ab_step_offset[COLOR_B_OFS_LSB +: OFS_W];
      default:      chan_offset = intensity_colorc_step_offset[COLOR_C_OFS_LSB +: OFS_W];
    endcase
  end

  led_duty_step u_step (
    .duty   (RAM_RD_DATA),
    .offset (chan_offset),
    .down   (step_down),
    .result (stepped_duty)
  );

  always_ff @(posedge CLK) begin
    if (RST) begin
      state <= S_IDLE;
    end else begin
      case (state)
        S_IDLE: begin
          if (step_pending && auto_mode) begin
            state <= S_CHECK;
          end
        end
        S_CHECK: begin
          if (!auto_mode) begin
            state <= S_IDLE;
          end else if (module_enabled) begin
            state <= S_WAIT;
          end else if (last_module) begin
            state <= S_IDLE;
          end
        end
        S_WAIT:  state <= S_WRITE;
        S_WRITE: state <= last_item ? S_IDLE : S_CHECK;
        default: state <= S_IDLE;
      endcase
    end
  end

  // walk COM, module, channel; skip disabled modules whole
  always_ff @(posedge CLK) begin
    if (RST) begin
      com_idx  <= 3'h0;
      mod_idx  <= 3'h0;
      chan_idx <= 2'h0;
    end else if (state == S_IDLE) begin
      com_idx  <= 3'h0;
      mod_idx  <= 3'h0;
      chan_idx <= 2'h0;
    end else if ((state == S_CHECK && !module_enabled) || state == S_WRITE) begin
      if (state == S_WRITE && chan_idx != 2'h3) begin
        chan_idx <= chan_idx + 2'h1;
      end else begin
        chan_idx <= 2'h0;
        if (mod_idx == 3'(NUM_MODULES - 1)) begin
          mod_idx <= 3'h0;
          com_idx <= com_idx + 3'h1;
        end else begin
          mod_idx <= mod_idx + 3'h1;
        end
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      RAM_WR_DATA <= {DUTY_W{1'b0}};
    end else if (state == S_WAIT) begin
      RAM_WR_DATA <= stepped_duty;
    end
  end

  assign RAM_ADDR  = {com_idx, mod_idx, chan_idx};
  assign RAM_RD_EN = (state == S_CHECK) && auto_mode && module_enabled;
  assign RAM_WR_EN = (state == S_WRITE);

endmodule // led_auto_stepper

// File: core/led_duty_step.sv
// saturating add or subtract of a step offset on one duty value
`timescale 1ns/100ps
module led_duty_step
  import led_step_pkg::*;
(
  input  wire logic [DUTY_W-1:0] duty,
  input  wire logic [OFS_W-1:0]  offset,
  input  wire logic              down,
  output logic      [DUTY_W-1:0] result
);

  logic [DUTY_W:0] sum;
  logic [DUTY_W:0] dif;

  always_comb begin
    sum = {1'b0, duty} + {{(DUTY_W + 1 - OFS_W){1'b0}}, offset};
    dif = {1'b0, duty} - {{(DUTY_W + 1 - OFS_W){1'b0}}, offset};
    if (down) begin
      // clamp at zero instead of wrapping
      result = dif[DUTY_W] ? {DUTY_W{1'b0}} : dif[DUTY_W-1:0];
    end else begin
      // clamp at full scale
      result = sum[DUTY_W] ? {DUTY_W{1'b1}} : sum[DUTY_W-1:0];
    end
  end

endmodule // led_duty_step

// File: dv/led_step_monitor.sv
// port assertions for the auto duty stepper
`timescale 1ns/100ps
module led_step_monitor
  import led_step_pkg::*;
(
  input wire logic                  CLK,
  input wire logic                  RST,
  input wire logic                  HSEL,
  input wire logic [1:0]            HTRANS,
  input wire logic                  HWRITE,
  input wire logic                  HREADY,
  input wire logic [31:0]           HRDATA,
  input wire logic                  HREADYOUT,
  input wire logic                  HRESP,
  input wire logic [RAM_ADDR_W-1:0] RAM_ADDR,
  input wire logic                  RAM_RD_EN,
  input wire logic                  RAM_WR_EN
);
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  a_bus_okay: assert property (HREADYOUT && !HRESP) else $error("bus not ready or not okay");
  a_rdata_hold: assert property ($changed(HRDATA) |-> $past(HSEL && HREADY && HTRANS[1] && !HWRITE))
    else $error("read data changed without a read");
  a_rd_then_wr: assert property (RAM_RD_EN |=> !RAM_RD_EN && !RAM_WR_EN ##1 RAM_WR_EN)
    else $error("read not followed by write back");
  a_wr_same_addr: assert property (RAM_WR_EN |-> $past(RAM_RD_EN, 2) && RAM_ADDR == $past(RAM_ADDR, 2))
    else $error("write back without matching read");
  a_wr_pulse: assert property (RAM_WR_EN |=> !RAM_WR_EN) else $error("write strobe too long");
  a_module_range: assert property (RAM_RD_EN |-> RAM_ADDR[4:2] < NUM_MODULES)
    else $error("access to missing module");
  a_addr_hold: assert property (RAM_RD_EN |=> $stable(RAM_ADDR) [*2]) else $error("address moved in item");
  a_reset_quiet: assert property (disable iff (1'b0) RST |=> !RAM_RD_EN && !RAM_WR_EN && HRDATA == 32'h0)
    else $error("outputs active after reset");
endmodule // led_step_monitor

bind led_auto_stepper led_step_monitor u_mon (.CLK, .RST, .HSEL, .HTRANS, .HWRITE, .HREADY, .HRDATA,
  .HREADYOUT, .HRESP, .RAM_ADDR, .RAM_RD_EN, .RAM_WR_EN);

// File: dv/tb_top.sv
// self-checking bench for the auto duty stepper
`timescale 1ns/100ps
module tb_top
  import led_step_pkg::*;
;
  logic                  CLK = 1'b0, RST = 1'b1, HSEL = 1'b0, HWRITE = 1'b0, FRAME_TICK = 1'b0;
  logic [31:0]           HADDR = 32'h0, HWDATA = 32'h0, HRDATA, rd;
  logic [1:0]            HTRANS = 2'h0;
  logic                  HREADYOUT, HRESP, RAM_RD_EN, RAM_WR_EN;
  logic [RAM_ADDR_W-1:0] RAM_ADDR;
  logic [DUTY_W-1:0]     RAM_RD_DATA = 6'h00, RAM_WR_DATA;
  logic [DUTY_W-1:0]     ram [256];
  logic [15:0]           rnd = 16'h74ab;
  logic [7:0]            ofs0, ofs1, en [8];
  int                    exp_ram [256];
  int                    err_count = 0, total_checks = 0, wr_count = 0, exp_wr = 0;
  bit                    down;

  led_auto_stepper dut (.CLK, .RST, .HSEL, .HADDR, .HTRANS, .HWRITE, .HSIZE(3'h2), .HWDATA, .HREADY(HREADYOUT),
    .HRDATA, .HREADYOUT, .HRESP, .FRAME_TICK, .RAM_ADDR, .RAM_RD_EN, .RAM_RD_DATA, .RAM_WR_EN, .RAM_WR_DATA);

  initial forever #25 CLK = ~CLK;

  // registered duty store; idle read data toggles
  always @(posedge CLK) begin
    RAM_RD_DATA <= (RAM_RD_EN === 1'b1) ? ram[RAM_ADDR] : ~RAM_RD_DATA;
    if (RAM_WR_EN === 1'b1) begin
      ram[RAM_ADDR] <= RAM_WR_DATA;
      wr_count <= wr_count + 1;
    end
  end

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    total_checks++;
    if (seen !== want) begin
      err_count++;
      $display("mismatch at %0t: got %h want %h", $time, seen, want);
    end
  endtask

  task automatic test_done();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic bus(input bit wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge CLK);
    HSEL <= 1'b1;
    HTRANS <= 2'h2;
    HWRITE <= wr;
    HADDR <= {24'h0, a};
    do @(posedge CLK); while (HREADYOUT !== 1'b1);
    HSEL <= 1'b0;
    HTRANS <= 2'h0;
    HWDATA <= d;
    do @(posedge CLK); while (HREADYOUT !== 1'b1);
    rd = HRDATA;
  endtask

  // n frame ticks, each followed by a wait until the pass is over
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge CLK);
      FRAME_TICK <= 1'b1;
      @(posedge CLK);
      FRAME_TICK <= 1'b0;
      repeat (3) @(posedge CLK);
      for (int i = 0; i < 400; i++) begin
        bus(0, ADDR_STATUS, 0);
        if (rd[1:0] === 2'b00) break;
      end
      chk(rd[1:0], 2'b00);
    end
  endtask

  task automatic model_step();
    int v, o;
    for (int a = 0; a < 256; a++) begin
      o = (a % 4 == 0) ? ofs1[7:4] : (a % 4 == 1) ? ofs0[3:0] : (a % 4 == 2) ? ofs0[7:4] : ofs1[3:0];
      v = exp_ram[a] + (down ? -o : o);
      if (en[a / 32][(a / 4) % 8]) begin
        exp_ram[a] = v < 0 ? 0 : (v > 63 ? 63 : v);
        exp_wr++;
      end
    end
  endtask

  task automatic check_ram();
    for (int a = 0; a < 256; a++) chk(ram[a], exp_ram[a]);
    chk(wr_count, exp_wr);
  endtask

  task automatic config_rand();
    rnd = lfsr(rnd);
    ofs0 = rnd[7:0];
    ofs1 = rnd[15:8];
    bus(1, ADDR_COLOR_AB_OFS, ofs0);
    bus(1, ADDR_INT_COLORC_OFS, ofs1);
    bus(0, ADDR_INT_COLORC_OFS, 0);
    chk(rd, ofs1);
    for (int c = 0; c < 8; c++) begin
      rnd = lfsr(rnd);
      en[c] = rnd[7:0] & 8'h1f;
      bus(1, ADDR_PAGE_A_EN_BASE + 8'(4 * c), rnd);
      bus(0, ADDR_PAGE_A_EN_BASE + 8'(4 * c), 0);
      chk(rd, en[c]);
    end
  endtask

  initial begin
    foreach (ram[a]) begin
      rnd = lfsr(rnd);
      ram[a] = rnd[5:0];
      exp_ram[a] = rnd[5:0];
    end
    repeat (2) @(posedge CLK);
    RST <= 1'b0;
    bus(1, 8'h14, 32'hff);
    for (int a = 0; a < 'h44; a += 4) begin
      bus(0, 8'(a), 0);
      chk(rd, 32'h0);
    end
    config_rand();
    bus(1, ADDR_FRAME_INTERVAL, 32'h2);
    tick(3);
    check_ram();
    down = 1'b0;
    bus(1, ADDR_CONTROL, 32'h1);
    tick(2);
    chk(wr_count, 0);
    bus(0, ADDR_STATUS, 0);
    chk(rd, 32'h2 << STAT_CNT_LSB);
    tick(1);
    model_step();
    check_ram();
    bus(1, ADDR_FRAME_INTERVAL, 32'h0);
    tick(2);
    check_ram();
    for (int k = 0; k < 5; k++) begin
      tick(1);
      model_step();
      check_ram();
      down = k[0];
      config_rand();
      bus(1, ADDR_CONTROL, {30'h0, down, 1'b1});
    end
    test_done();
  end

  initial begin
    repeat (60000) @(posedge CLK);
    err_count++;
    test_done();
  end
endmodule // tb_top

// File: pkg/led_step_pkg.sv
// constants and types shared by the auto duty stepper
package led_step_pkg;

  // geometry of the duty store
  localparam int unsigned NUM_MODULES = 5;
  localparam int unsigned NUM_COMS    = 8;
  localparam int unsigned NUM_CHANS   = 4;
  localparam int unsigned DUTY_W      = 6;
  localparam int unsigned OFS_W       = 4;
  localparam int unsigned RAM_ADDR_W  = 8;

  // register byte addresses
  localparam logic [7:0] ADDR_COLOR_AB_OFS   = 8'h00;
  localparam logic [7:0] ADDR_INT_COLORC_OFS = 8'h04;
  localparam logic [7:0] ADDR_FRAME_INTERVAL = 8'h08;
  localparam logic [7:0] ADDR_CONTROL        = 8'h0c;
  localparam logic [7:0] ADDR_STATUS         = 8'h10;
  localparam logic [7:0] ADDR_PAGE_A_EN_BASE = 8'h20;
  localparam logic [7:0] ADDR_PAGE_A_EN_LAST = 8'h3c;

  // field positions
  localparam int unsigned COLOR_B_OFS_LSB   = 4;
  localparam int unsigned COLOR_A_OFS_LSB   = 0;
  localparam int unsigned INTENSITY_OFS_LSB = 4;
  localparam int unsigned COLOR_C_OFS_LSB   = 0;
  localparam int unsigned CTRL_AUTO_BIT     = 0;
  localparam int unsigned CTRL_DOWN_BIT     = 1;
  localparam int unsigned STAT_BUSY_BIT     = 0;
  localparam int unsigned STAT_PEND_BIT     = 1;
  localparam int unsigned STAT_CNT_LSB      = 8;

  // channel codes in the duty store address
  localparam logic [1:0] CH_INTENSITY = 2'h0;
  localparam logic [1:0] CH_COLOR_A   = 2'h1;
  localparam logic [1:0] CH_COLOR_B   = 2'h2;
  localparam logic [1:0] CH_COLOR_C   = 2'h3;

  // reset values
  localparam logic [7:0] RST_OFFSET   = 8'h00;
  localparam logic [7:0] RST_INTERVAL = 8'h00;
  localparam logic [4:0] RST_ENABLE   = 5'h00;
  localparam logic [1:0] RST_CONTROL  = 2'h0;

  typedef enum logic [3:0] {
    S_IDLE  = 4'b0001,
    S_CHECK = 4'b0010,
    S_WAIT  = 4'b0100,
    S_WRITE = 4'b1000
  } step_state_t;

endpackage
